// ---- core/gsc_pkg.sv ----
package gsc_pkg;
    // ========================================
    // register offsets
    localparam logic [7:0] GSC_OFS_OUT_LEVEL = 8'h0B;
    localparam logic [7:0] GSC_OFS_IN_LEVEL = 8'h0D;
    localparam logic [7:0] GSC_OFS_BLANKING = 8'h0F;
    localparam logic [7:0] GSC_OFS_SCAN_CTRL = 8'h10;
    localparam logic [7:0] GSC_OFS_MANUAL_SEL = 8'h11;

    // ========================================
    // field positions
    localparam int GSC_BLANK_MULT_BIT = 7;
    localparam int GSC_SCAN_RUN_BIT = 4;
    localparam int GSC_MULT_SHIFT = 3;

    // ========================================
    // reset values and the last channel index
    localparam logic [7:0] GSC_RST_BYTE = 8'h00;
    localparam logic [9:0] GSC_RST_BLANK = 10'h000;
    localparam logic [2:0] GSC_RST_CH = 3'h0;
    localparam logic [2:0] GSC_LAST_CH = 3'h7;

    // ========================================
    // types
    typedef enum logic [1:0] {
        GSC_MODE_MANUAL = 2'b00,
        GSC_MODE_AUTO = 2'b01,
        GSC_MODE_RSVD2 = 2'b10,
        GSC_MODE_RSVD3 = 2'b11
    } gsc_mode_e;

    typedef struct packed {
        logic [7:0] output_level_bits;
        logic blanking_multiplier_enable;
        logic [6:0] blanking_conversion_count;
        logic scan_run;
        gsc_mode_e scan_mode_select;
        logic [3:0] manual_channel_id;
    } gsc_cfg_s;

    localparam gsc_cfg_s GSC_RST_CFG = '0;
endpackage

// ---- core/gsc_regs.sv ----
`timescale 1ns/10ps
// Functional notes
// - output level register bits set each digital output: 0 low, 1 high
// - input level register reads the sampled pin level of each channel
// - after a crossing event, ignore blanking-count conversions before the next event
// - multiplier bit clear: count equals field; set: count equals field times eight
// - auto mode with scan run set steps enabled channels ascending; clear stops
// - mode 00 takes manual channel, 01 the sequencer; 10 and 11 reserved
// - manual codes 0 to 7 select inputs 0 to 7; 8 and above reserved
// - reserved bits in scan control and manual select read as zero
// - every register of the bank resets to zero
// - per-channel function bit: 0 analog input, 1 digital use
// - direction bit: 0 input, 1 output; levels drive only output channels
// - automatic scanning visits only channels set in the enable mask
module gsc_regs
    import gsc_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // register access from the serial host logic
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    output logic REG_RVALID,
    // channel configuration held elsewhere
    input wire logic [7:0] PIN_FUNC,
    input wire logic [7:0] PIN_DIR,
    input wire logic [7:0] SCAN_CHANNEL_ENABLE_MASK,
    // channel pins
    input wire logic [7:0] GPIO_IN,
    output logic [7:0] GPIO_OUT,
    output logic [7:0] GPIO_OE,
    // converter handshake
    input wire logic CONV_DONE,
    input wire logic ZC_CONV_DONE,
    input wire logic ZC_CROSSING,
    // scan and crossing results
    output logic [2:0] SCAN_CH,
    output logic SCAN_CH_VALID,
    output logic SCAN_ACTIVE,
    output logic ZC_EVENT,
    output logic ZC_BLANKING
);

    // ========================================
    // state
    gsc_cfg_s cfg_q;
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [9:0] blank_q;
    logic [9:0] blank_d;
    logic [2:0] ch_q;
    logic [2:0] ch_d;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [7:0] out_q;
    logic [7:0] oe_q;
    logic [2:0] scan_ch_q;
    logic scan_valid_q;
    logic scan_active_q;
    logic zc_event_q;
    logic zc_blank_q;

    // ========================================
    // address decode
    wire wr_out = REG_WR && (REG_ADDR == GSC_OFS_OUT_LEVEL);
    wire wr_blank = REG_WR && (REG_ADDR == GSC_OFS_BLANKING);
    wire wr_scan = REG_WR && (REG_ADDR == GSC_OFS_SCAN_CTRL);
    wire wr_manual = REG_WR && (REG_ADDR == GSC_OFS_MANUAL_SEL);
    wire gsc_mode_e wr_mode = gsc_mode_e'(REG_WDATA[1:0]);

    // read view; reserved bits and unmapped offsets read zero
    wire [7:0] rd_blank = {cfg_q.blanking_multiplier_enable, cfg_q.blanking_conversion_count};
    wire [7:0] rd_scan = {3'h0, cfg_q.scan_run, 2'h0, cfg_q.scan_mode_select};
    wire [7:0] rd_manual = {4'h0, cfg_q.manual_channel_id};
    wire [7:0] rd_mux =
        (REG_ADDR == GSC_OFS_OUT_LEVEL) ? cfg_q.output_level_bits :
        (REG_ADDR == GSC_OFS_IN_LEVEL) ? sync2_q :
        (REG_ADDR == GSC_OFS_BLANKING) ? rd_blank :
        (REG_ADDR == GSC_OFS_SCAN_CTRL) ? rd_scan :
        (REG_ADDR == GSC_OFS_MANUAL_SEL) ? rd_manual : GSC_RST_BYTE;

    // ========================================
    // blanking count; x8 is a shift, so the widest count is 1016
    // a crossing seen while blanking is dropped, not queued for later
    wire [9:0] blank_load = cfg_q.blanking_multiplier_enable ?
        {cfg_q.blanking_conversion_count, 3'h0} :
        {3'h0, cfg_q.blanking_conversion_count};
    wire zc_fire = ZC_CONV_DONE && ZC_CROSSING && (blank_q == GSC_RST_BLANK);

    always_comb begin
        blank_d = blank_q;
        if (zc_fire) begin
            blank_d = blank_load;
        end else if (ZC_CONV_DONE && (blank_q != GSC_RST_BLANK)) begin
            blank_d = blank_q - 10'h001;
        end
    end

    // ========================================
    // scan channel selection
    // first enabled channel above cur, wrapping; mask of zero gives cur back
    // an empty mask parks the sequencer and drops valid rather than wander
    function automatic logic [2:0] next_enabled(input logic [2:0] cur, input logic [7:0] mask);
        logic [2:0] pick;
        logic [2:0] idx;
        pick = cur;
        for (int i = 8; i >= 1; i--) begin
            idx = cur + 3'(i);
            if (mask[idx]) begin
                pick = idx;
            end
        end
        return pick;
    endfunction

    wire auto_mode = (cfg_q.scan_mode_select == GSC_MODE_AUTO);
    wire manual_mode = (cfg_q.scan_mode_select == GSC_MODE_MANUAL);
    wire auto_run = auto_mode && cfg_q.scan_run;
    wire mask_any = |SCAN_CHANNEL_ENABLE_MASK;
    wire manual_ok = manual_mode && !cfg_q.manual_channel_id[3];
    wire [2:0] first_ch = next_enabled(GSC_LAST_CH, SCAN_CHANNEL_ENABLE_MASK);
    wire [2:0] step_ch = next_enabled(ch_q, SCAN_CHANNEL_ENABLE_MASK);
    wire ch_enabled = SCAN_CHANNEL_ENABLE_MASK[ch_q];

    // idle sequencer parks on the lowest enabled channel so a start begins there
    always_comb begin
        ch_d = ch_q;
        if (!auto_run || !ch_enabled) begin
            ch_d = first_ch;
        end else if (CONV_DONE) begin
            ch_d = step_ch;
        end
    end

    wire [2:0] sel_ch = manual_mode ? cfg_q.manual_channel_id[2:0] : ch_d;
    wire sel_valid = manual_ok || (auto_run && mask_any);

    // ========================================
    // configuration registers; the input level offset has no write path
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cfg_q <= GSC_RST_CFG;
        end else begin
            if (wr_out) begin
                cfg_q.output_level_bits <= REG_WDATA;
            end
            if (wr_blank) begin
                cfg_q.blanking_multiplier_enable <= REG_WDATA[GSC_BLANK_MULT_BIT];
                cfg_q.blanking_conversion_count <= REG_WDATA[6:0];
            end
            if (wr_scan) begin
                cfg_q.scan_run <= REG_WDATA[GSC_SCAN_RUN_BIT];
                cfg_q.scan_mode_select <= wr_mode;
            end
            if (wr_manual) begin
                cfg_q.manual_channel_id <= REG_WDATA[3:0];
            end
        end
    end

    // ========================================
    // pin synchroniser; the level register is the second stage itself
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sync1_q <= GSC_RST_BYTE;
            sync2_q <= GSC_RST_BYTE;
        end else begin
            sync1_q <= GPIO_IN;
            sync2_q <= sync1_q;
        end
    end

    // ========================================
    // read answer, one cycle after the strobe
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_q <= GSC_RST_BYTE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= REG_RD;
            if (REG_RD) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ========================================
    // pin drive: level only on digital output channels
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            out_q <= GSC_RST_BYTE;
            oe_q <= GSC_RST_BYTE;
        end else begin
            out_q <= cfg_q.output_level_bits;
            oe_q <= PIN_FUNC & PIN_DIR;
        end
    end

    // ========================================
    // crossing blanking counter
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            blank_q <= GSC_RST_BLANK;
            zc_event_q <= 1'b0;
            zc_blank_q <= 1'b0;
        end else begin
            blank_q <= blank_d;
            zc_event_q <= zc_fire;
            zc_blank_q <= (blank_d != GSC_RST_BLANK);
        end
    end

    // ========================================
    // sequencer and channel outputs
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ch_q <= GSC_RST_CH;
            scan_ch_q <= GSC_RST_CH;
            scan_valid_q <= 1'b0;
            scan_active_q <= 1'b0;
        end else begin
            ch_q <= ch_d;
            scan_ch_q <= sel_ch;
            scan_valid_q <= sel_valid;
            scan_active_q <= auto_run && mask_any;
        end
    end

    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign GPIO_OUT = out_q;
    assign GPIO_OE = oe_q;
    assign SCAN_CH = scan_ch_q;
    assign SCAN_CH_VALID = scan_valid_q;
    assign SCAN_ACTIVE = scan_active_q;
    assign ZC_EVENT = zc_event_q;
    assign ZC_BLANKING = zc_blank_q;

    // ========================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    out_level_a: assert property (
        wr_out ##1 !wr_out |=> GPIO_OUT == $past(REG_WDATA, 2)
    ) else $error("output level not driven from written value");

    oe_gate_a: assert property (
        ##1 GPIO_OE == $past(PIN_FUNC & PIN_DIR)
    ) else $error("output enable not limited to digital outputs");

    in_read_a: assert property (
        REG_RD && (REG_ADDR == GSC_OFS_IN_LEVEL) |=> REG_RVALID && REG_RDATA == $past(sync2_q)
    ) else $error("input level read does not match sampled pins");

    blank_load_a: assert property (
        zc_fire |=> blank_q == ($past(cfg_q.blanking_multiplier_enable) ?
            {$past(cfg_q.blanking_conversion_count), 3'h0} :
            {3'h0, $past(cfg_q.blanking_conversion_count)})
    ) else $error("blanking count loaded wrongly");

    blank_hold_a: assert property (
        (blank_q != GSC_RST_BLANK) |-> ##1 !ZC_EVENT
    ) else $error("crossing event during blanking");

    zc_fire_a: assert property (
        ZC_CONV_DONE && ZC_CROSSING && (blank_q == GSC_RST_BLANK) |=> ZC_EVENT
    ) else $error("crossing outside blanking gave no event");

    blank_flag_a: assert property (
        ZC_BLANKING == (blank_q != GSC_RST_BLANK)
    ) else $error("blanking flag does not follow the counter");

    in_ro_a: assert property (
        REG_WR && (REG_ADDR == GSC_OFS_IN_LEVEL) |=> $stable(cfg_q)
    ) else $error("write to input level register changed state");

    scan_step_a: assert property (
        SCAN_ACTIVE && !manual_mode |-> SCAN_CHANNEL_ENABLE_MASK[ch_q] || $changed(SCAN_CHANNEL_ENABLE_MASK)
    ) else $error("sequencer on a disabled channel");

    scan_stop_a: assert property (
        !cfg_q.scan_run |=> !SCAN_ACTIVE
    ) else $error("scanning continues after stop");

    manual_ch_a: assert property (
        manual_mode && !cfg_q.manual_channel_id[3] |=>
            SCAN_CH_VALID && SCAN_CH == $past(cfg_q.manual_channel_id[2:0])
    ) else $error("manual channel not applied");

    rsvd_mode_a: assert property (
        cfg_q.scan_mode_select[1] |=> !SCAN_CH_VALID
    ) else $error("reserved scan mode produced a channel");

    rsvd_bits_a: assert property (
        REG_RD && (REG_ADDR == GSC_OFS_SCAN_CTRL) |=> REG_RDATA[7:5] == 3'h0 && REG_RDATA[3:2] == 2'h0
    ) else $error("reserved scan control bits read nonzero");

endmodule

// ---- test/gpio_and_scan_control_regs_tb.sv ----
`timescale 1ns/10ps
// ========================================
// bench for the channel register bank
module gpio_and_scan_control_regs_tb
    import gsc_pkg::*;
;
    logic clk, reset_n, reg_wr, reg_rd, rvalid, conv_done, zc_done, zc_cross;
    logic ch_valid, active, zc_event, zc_blank;
    logic [7:0] reg_addr, reg_wdata, rdata, pin_func, pin_dir, mask, gpio_in, gpio_out, gpio_oe;
    logic [7:0] v;
    logic [2:0] scan_ch;
    logic [7:0] exp_q[$];
    logic [7:0] regs[5] = '{GSC_OFS_OUT_LEVEL, GSC_OFS_IN_LEVEL, GSC_OFS_BLANKING,
                            GSC_OFS_SCAN_CTRL, GSC_OFS_MANUAL_SEL};
    int n_mismatch = 0;
    int checked = 0;

    gsc_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));

    gsc_regs DUT (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .REG_RVALID(rvalid),
        .PIN_FUNC(pin_func), .PIN_DIR(pin_dir), .SCAN_CHANNEL_ENABLE_MASK(mask),
        .GPIO_IN(gpio_in), .GPIO_OUT(gpio_out), .GPIO_OE(gpio_oe), .CONV_DONE(conv_done),
        .ZC_CONV_DONE(zc_done), .ZC_CROSSING(zc_cross), .SCAN_CH(scan_ch),
        .SCAN_CH_VALID(ch_valid), .SCAN_ACTIVE(active), .ZC_EVENT(zc_event),
        .ZC_BLANKING(zc_blank));

    // ========================================
    // helpers
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // note the expected byte first, so the monitor never races the answer
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    // settle past the edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // one crossing-channel conversion; the event pulse stands one cycle only
    task automatic zc(input logic c, input logic e);
        @(posedge clk);
        zc_done <= 1'b1;
        zc_cross <= c;
        @(posedge clk);
        zc_done <= 1'b0;
        #1 chk("crossing event", {7'h00, e}, {7'h00, zc_event});
    endtask

    task automatic step(input logic [2:0] ch);
        @(posedge clk);
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        tick(1);
        chk("scan channel", {5'h00, ch}, {5'h00, scan_ch});
    endtask

    // ========================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end

    // read monitor: oldest note against each answer
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("CHECK FAILED read data expected none seen %h", rdata);
            end else begin
                chk("read data", exp_q.pop_front(), rdata);
            end
        end
    end

    // ========================================
    // main sequence
    initial begin
        void'($urandom(97994));
        reset_n = 1'b0;
        {pin_func, pin_dir, mask, gpio_in} = '0;
        {conv_done, zc_done, zc_cross} = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        foreach (regs[i]) rd(regs[i], GSC_RST_BYTE);
        v = 8'($urandom());
        host.wr(GSC_OFS_OUT_LEVEL, v);
        rd(GSC_OFS_OUT_LEVEL, v);
        tick(1);
        chk("output pins", v, gpio_out);
        @(posedge clk);
        pin_func <= 8'($urandom());
        pin_dir <= 8'($urandom());
        tick(2);
        chk("output enable", pin_func & pin_dir, gpio_oe);
        @(posedge clk);
        gpio_in <= 8'($urandom());
        tick(4);
        rd(GSC_OFS_IN_LEVEL, gpio_in);
        host.wr(GSC_OFS_IN_LEVEL, ~gpio_in);
        rd(GSC_OFS_IN_LEVEL, gpio_in);
        host.wr(8'h12, 8'hFF);
        rd(8'h12, 8'h00);
        // reserved modes with run set and a nonempty mask must stay idle
        mask <= 8'hA4;
        for (int i = 0; i < 2; i++) begin
            v = 8'hFE | 8'(i);
            host.wr(GSC_OFS_SCAN_CTRL, v);
            rd(GSC_OFS_SCAN_CTRL, v & 8'h13);
            #1 chk("reserved mode", 8'h00, {6'h00, ch_valid, active});
        end
        host.wr(GSC_OFS_MANUAL_SEL, 8'hF8);
        rd(GSC_OFS_MANUAL_SEL, 8'h08);
        pin_func <= 8'h00;
        host.wr(GSC_OFS_SCAN_CTRL, 8'h00);
        for (int i = 0; i < 10; i++) begin
            host.wr(GSC_OFS_MANUAL_SEL, 8'(i));
            tick(2);
            chk("channel valid", {7'h00, i < 8}, {7'h00, ch_valid});
            if (i < 8) chk("manual channel", 8'(i), {5'h00, scan_ch});
        end
        host.wr(GSC_OFS_SCAN_CTRL, 8'h11);
        tick(2);
        chk("scan active", 8'h01, {7'h00, active});
        chk("first channel", 8'h02, {5'h00, scan_ch});
        step(3'd5);
        step(3'd7);
        step(3'd2);
        host.wr(GSC_OFS_SCAN_CTRL, 8'h01);
        tick(2);
        chk("scan stopped", 8'h00, {7'h00, active});
        host.wr(GSC_OFS_BLANKING, 8'h02);
        zc(1'b1, 1'b1);
        chk("blanking", 8'h01, {7'h00, zc_blank});
        zc(1'b1, 1'b0);
        zc(1'b1, 1'b0);
        chk("blanking end", 8'h00, {7'h00, zc_blank});
        zc(1'b1, 1'b1);
        zc(1'b0, 1'b0);
        zc(1'b0, 1'b0);
        host.wr(GSC_OFS_BLANKING, 8'h81);
        rd(GSC_OFS_BLANKING, 8'h81);
        zc(1'b1, 1'b1);
        repeat (8) zc(1'b1, 1'b0);
        zc(1'b1, 1'b1);
        // bounded drain of outstanding reads
        for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clk);
        if (exp_q.size() != 0) n_mismatch++;
        end_of_test();
    end
endmodule

// ---- test/gsc_host_model.sv ----
`timescale 1ns/10ps
// ========================================
// serial host side: single-byte register accesses
module gsc_host_model (
    // clock
    input wire logic clk,
    // register strobes
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    // strobes idle low from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // one-cycle write pulse; address and data held through the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // one-cycle read pulse; the answer is collected by the bench monitor
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
endmodule
